/* File: verilog/imdma_core.sv */
// Interrupt controller with four-channel fast micro DMA
`default_nettype none
module imdma_core
  import imdma_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [NSRC-1:0] i_irq_src,
  input wire logic i_bus_release_ack,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_addr,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  input wire logic i_ctl_wr,
  input wire logic i_ctl_rd,
  input wire logic i_ctl_priv,
  input wire logic [1:0] i_ctl_ch,
  input wire logic [1:0] i_ctl_reg,
  input wire logic [31:0] i_ctl_wdata,
  output logic [31:0] o_ctl_rdata,
  input wire logic i_interrupt_return,
  input wire logic [2:0] i_interrupt_return_mask,
  output logic o_int_req,
  output logic [7:0] o_int_vec,
  output logic [2:0] o_saved_mask,
  output logic [2:0] o_cpu_priority_mask,
  output logic o_busy,
  output logic [ADDR_OUT_W-1:0] o_bus_addr,
  output logic o_bus_rd,
  output logic o_bus_wr,
  output logic o_bus_word,
  output logic [15:0] o_bus_wdata,
  input wire logic [15:0] i_bus_rdata
);

  imdma_state_type st_r;
  imdma_state_type st_nxt;
  logic win_any;
  logic [4:0] win_idx;
  logic [2:0] win_lvl;
  logic accept;
  logic dma_hit;
  logic [1:0] dma_ch;
  logic [2:0] lvl_eff;
  logic [31:0] step;
  logic [7:0] md;
  logic last_cyc;

  // ==========================================================
  // Arbitration
  always_comb begin
    win_any = 1'b0;
    win_idx = 5'h00;
    win_lvl = LVL_DIS;
    lvl_eff = LVL_DIS;
    for (int i = NSRC - 1; i >= 0; i--) begin
      // Non-maskable sources sit at the top level; 0 and 7 disable the rest
      if (i < NNMI) lvl_eff = LVL_TOP;
      else if (st_r.lvl[i] == LVL_TOP) lvl_eff = LVL_DIS;
      else lvl_eff = st_r.lvl[i];
      // Downward scan with >= lets the smaller vector win a tie
      if (st_r.latch[i] && lvl_eff != LVL_DIS && lvl_eff >= win_lvl) begin
        win_any = 1'b1;
        win_idx = 5'(i);
        win_lvl = lvl_eff;
      end
    end
  end

  // A running DMA service or released bus holds every request off
  assign accept = win_any && st_r.fsm == ST_IDLE && st_r.bsync[1]
    && (win_idx < 5'(NNMI) || win_lvl > st_r.mask);

  always_comb begin
    dma_hit = 1'b0;
    dma_ch = 2'h0;
    for (int c = NCH - 1; c >= 0; c--) begin
      // Zero never matches; downward scan leaves the lowest channel
      if (st_r.svec[c] != SV_RESET && st_r.svec[c] == imdma_vec_of(win_idx)) begin
        dma_hit = 1'b1;
        dma_ch = 2'(c);
      end
    end
  end

  assign md = st_r.mode[st_r.ch];
  assign step = md[0] ? 32'h0000_0002 : 32'h0000_0001;
  assign last_cyc = st_r.cyc == imdma_dur_of(md) - 5'h01;

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.bsync = {st_r.bsync[0], i_bus_release_ack};
    st_nxt.int_req = 1'b0;
    st_nxt.bus_rd = 1'b0;
    st_nxt.bus_wr = 1'b0;

    // I/O side: levels, clear bits and start vectors
    if (i_io_wr) begin
      for (int i = 0; i < NSRC; i++) begin
        if (i_io_addr == IO_PRIO_BASE + 8'(i)) begin
          st_nxt.lvl[i] = i_io_wdata[2:0];
          if (!i_io_wdata[PRIO_CLR_BIT]) st_nxt.latch[i] = 1'b0;
        end
      end
      for (int c = 0; c < NCH; c++) begin
        if (i_io_addr == IO_SV_BASE + 8'(c)) st_nxt.svec[c] = i_io_wdata;
      end
    end
    if (i_io_rd) begin
      st_nxt.io_rdata = 8'h00;
      for (int i = 0; i < NSRC; i++) begin
        if (i_io_addr == IO_PRIO_BASE + 8'(i)) begin
          st_nxt.io_rdata = {4'h0, st_r.latch[i], st_r.lvl[i]};
        end
      end
      for (int c = 0; c < NCH; c++) begin
        if (i_io_addr == IO_SV_BASE + 8'(c)) st_nxt.io_rdata = st_r.svec[c];
      end
    end

    // Privileged control load only; plain accesses leave them alone
    if (i_ctl_wr && i_ctl_priv) begin
      case (i_ctl_reg)
        CR_SRC: st_nxt.src[i_ctl_ch] = i_ctl_wdata;
        CR_DST: st_nxt.dst[i_ctl_ch] = i_ctl_wdata;
        CR_CNT: st_nxt.cnt[i_ctl_ch] = i_ctl_wdata[15:0];
        default: st_nxt.mode[i_ctl_ch] = i_ctl_wdata[7:0];
      endcase
    end
    if (i_ctl_rd) begin
      case (i_ctl_reg)
        CR_SRC: st_nxt.ctl_rdata = st_r.src[i_ctl_ch];
        CR_DST: st_nxt.ctl_rdata = st_r.dst[i_ctl_ch];
        CR_CNT: st_nxt.ctl_rdata = {16'h0000, st_r.cnt[i_ctl_ch]};
        default: st_nxt.ctl_rdata = {24'h00_0000, st_r.mode[i_ctl_ch]};
      endcase
    end

    if (i_interrupt_return) st_nxt.mask = i_interrupt_return_mask;

    case (st_r.fsm)
      ST_IDLE: begin
        if (accept) begin
          st_nxt.latch[win_idx] = 1'b0;
          st_nxt.src_idx = win_idx;
          if (dma_hit) begin
            st_nxt.fsm = ST_RUN;
            st_nxt.ch = dma_ch;
            st_nxt.cyc = 5'h00;
            // Zero wraps to FFFF, so a zero start gives 65536 runs
            st_nxt.cnt[dma_ch] = st_r.cnt[dma_ch] - 16'h0001;
            st_nxt.zero_hit = st_r.cnt[dma_ch] == 16'h0001;
          end else begin
            st_nxt.int_req = 1'b1;
            st_nxt.int_vec = imdma_vec_of(win_idx);
            st_nxt.saved_mask = st_r.mask;
            st_nxt.mask = (win_lvl == LVL_TOP) ? LVL_TOP : win_lvl + 3'h1;
          end
        end
      end
      ST_RUN: begin
        st_nxt.cyc = st_r.cyc + 5'h01;
        if (st_r.cyc == CYC_READ && md[3:0] != MD_COUNT) begin
          st_nxt.bus_rd = 1'b1;
          st_nxt.bus_addr = st_r.src[st_r.ch][ADDR_OUT_W-1:0];
          st_nxt.bus_word = md[3:0] == MD_REFRESH ? 1'b1 : md[0];
        end
        // Refresh and counting modes never write
        if (st_r.cyc == CYC_WRITE && md[3:1] <= MD_FIXED) begin
          st_nxt.bus_wr = 1'b1;
          st_nxt.bus_addr = st_r.dst[st_r.ch][ADDR_OUT_W-1:0];
          st_nxt.bus_word = md[0];
          st_nxt.bus_wdata = i_bus_rdata;
          st_nxt.data = i_bus_rdata;
        end
        if (last_cyc) begin
          st_nxt.fsm = ST_IDLE;
          case (md[3:1])
            MD_DST_INC: st_nxt.dst[st_r.ch] = st_r.dst[st_r.ch] + step;
            MD_DST_DEC: st_nxt.dst[st_r.ch] = st_r.dst[st_r.ch] - step;
            MD_SRC_INC: st_nxt.src[st_r.ch] = st_r.src[st_r.ch] + step;
            MD_SRC_DEC: st_nxt.src[st_r.ch] = st_r.src[st_r.ch] - step;
            default: begin
              // Fixed and counting modes keep both addresses
              if (md[3:0] == MD_REFRESH) begin
                st_nxt.src[st_r.ch][15:0] = st_r.src[st_r.ch][15:0] + REFRESH_STEP[15:0];
              end
            end
          endcase
          // Count reaching zero outside refresh mode hands over to ordinary service
          if (st_r.zero_hit && md[3:0] != MD_REFRESH) begin
            st_nxt.int_req = 1'b1;
            st_nxt.int_vec = imdma_vec_of(st_r.src_idx);
            st_nxt.saved_mask = st_r.mask;
            st_nxt.mask = (st_r.src_idx < 5'(NNMI) || st_r.lvl[st_r.src_idx] == LVL_TOP)
              ? LVL_TOP : st_r.lvl[st_r.src_idx] + 3'h1;
          end
        end
      end
      default: st_nxt.fsm = ST_IDLE;
    endcase

    // A new request beats a clear in the same cycle
    st_nxt.latch = st_nxt.latch | i_irq_src;
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
      st_r.mask <= MASK_RESET;
      st_r.fsm <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_io_rdata = st_r.io_rdata;
  assign o_ctl_rdata = st_r.ctl_rdata;
  assign o_int_req = st_r.int_req;
  assign o_int_vec = st_r.int_vec;
  assign o_saved_mask = st_r.saved_mask;
  assign o_cpu_priority_mask = st_r.mask;
  assign o_busy = st_r.fsm == ST_RUN;
  assign o_bus_addr = st_r.bus_addr;
  assign o_bus_rd = st_r.bus_rd;
  assign o_bus_wr = st_r.bus_wr;
  assign o_bus_word = st_r.bus_word;
  assign o_bus_wdata = st_r.bus_wdata;

  // ==========================================================
  // Assertions
  latch_set_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    |i_irq_src |=> (st_r.latch & $past(i_irq_src)) == $past(i_irq_src))
    else $error("request latch missed a set");
  bus_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !st_r.bsync[1] && !o_busy |=> !o_busy && !o_int_req)
    else $error("accepted while bus released");
  mask_raise_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    accept && !dma_hit && win_lvl < LVL_TOP && !i_interrupt_return |=> o_cpu_priority_mask ==
    $past(win_lvl) + 3'h1 && o_int_req) else $error("mask not level plus one");
  interrupt_return_load_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_interrupt_return && !accept && st_r.fsm == ST_IDLE |=> o_cpu_priority_mask == $past(i_interrupt_return_mask))
    else $error("return did not reload mask");
  cnt_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    accept && dma_hit && !(i_ctl_wr && i_ctl_priv) |=> st_r.cnt[st_r.ch] ==
    $past(st_r.cnt[dma_ch]) - 16'h0001 && o_busy) else $error("count not decremented");
  run_len_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_busy && !$past(o_busy) && md[3:0] == MD_COUNT |-> o_busy[*8] ##4 !o_busy)
    else $error("counting service not 11 states");
  refresh_quiet_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_busy && last_cyc && md[3:0] == MD_REFRESH |=> !o_int_req && !o_bus_wr)
    else $error("refresh raised interrupt");
  priv_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_ctl_wr && !i_ctl_priv && !o_busy && !accept |=> $stable(st_r.mode) && $stable(st_r.cnt))
    else $error("unprivileged control write landed");
  read_wr_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_bus_rd && md[3:0] != MD_REFRESH |=> o_bus_wr) else $error("read not followed by write");

  dma_run_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    accept && dma_hit);
  zero_int_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_busy && last_cyc && st_r.zero_hit);
  plain_int_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    accept && !dma_hit);
  refresh_c: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    o_bus_rd && md[3:0] == MD_REFRESH);

endmodule : imdma_core
`default_nettype wire

/* File: verilog/imdma_pkg.sv */
// Constants and types for the interrupt-driven micro DMA block
`default_nettype none
package imdma_pkg;
  localparam int NSRC = 20;
  localparam int NCH = 4;
  localparam int NNMI = 2;
  // I/O register map (byte addresses on the I/O port)
  localparam logic [7:0] IO_PRIO_BASE = 8'h00;
  localparam logic [7:0] IO_SV_BASE = 8'h20;
  localparam int PRIO_CLR_BIT = 3;
  localparam logic [2:0] LVL_DIS = 3'h0;
  localparam logic [2:0] LVL_TOP = 3'h7;
  localparam logic [2:0] MASK_RESET = 3'h7;
  localparam logic [7:0] SV_RESET = 8'h00;
  // Privileged control register select
  localparam logic [1:0] CR_SRC = 2'h0;
  localparam logic [1:0] CR_DST = 2'h1;
  localparam logic [1:0] CR_CNT = 2'h2;
  localparam logic [1:0] CR_MODE = 2'h3;
  // Transfer mode codes (bits 3:1, bit 0 = size; refresh and count codes use bits 3:0)
  localparam logic [2:0] MD_DST_INC = 3'h0;
  localparam logic [2:0] MD_DST_DEC = 3'h1;
  localparam logic [2:0] MD_SRC_INC = 3'h2;
  localparam logic [2:0] MD_SRC_DEC = 3'h3;
  localparam logic [2:0] MD_FIXED = 3'h4;
  localparam logic [3:0] MD_REFRESH = 4'hA;
  localparam logic [3:0] MD_COUNT = 4'hB;
  localparam logic [31:0] REFRESH_STEP = 32'h0000_0004;
  // Service lengths in states, one state per system clock
  localparam logic [4:0] DUR_XFER = 5'h10;
  localparam logic [4:0] DUR_REFRESH = 5'h0E;
  localparam logic [4:0] DUR_COUNT = 5'h0B;
  localparam logic [4:0] CYC_READ = 5'h01;
  localparam logic [4:0] CYC_WRITE = 5'h02;
  localparam int ADDR_OUT_W = 24;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } imdma_fsm_type;

  typedef struct packed {
    logic [1:0] bsync;
    logic [NSRC-1:0] latch;
    logic [NSRC-1:0][2:0] lvl;
    logic [NCH-1:0][7:0] svec;
    logic [NCH-1:0][31:0] src;
    logic [NCH-1:0][31:0] dst;
    logic [NCH-1:0][15:0] cnt;
    logic [NCH-1:0][7:0] mode;
    logic [2:0] mask;
    imdma_fsm_type fsm;
    logic [1:0] ch;
    logic [4:0] cyc;
    logic [4:0] src_idx;
    logic zero_hit;
    logic [15:0] data;
    logic int_req;
    logic [7:0] int_vec;
    logic [2:0] saved_mask;
    logic [7:0] io_rdata;
    logic [31:0] ctl_rdata;
    logic [ADDR_OUT_W-1:0] bus_addr;
    logic bus_rd;
    logic bus_wr;
    logic bus_word;
    logic [15:0] bus_wdata;
  } imdma_state_type;

  function automatic logic [7:0] imdma_vec_of(input logic [4:0] idx);
    // Sources 0..6 use codes 08..0E, the rest skip reserved 0F
    imdma_vec_of = (idx < 5'd7) ? (8'h08 + {3'h0, idx}) : (8'h09 + {3'h0, idx});
  endfunction : imdma_vec_of

  function automatic logic [4:0] imdma_dur_of(input logic [7:0] md);
    if (md[3:0] == MD_REFRESH) imdma_dur_of = DUR_REFRESH;
    else if (md[3:0] == MD_COUNT) imdma_dur_of = DUR_COUNT;
    else imdma_dur_of = DUR_XFER;
  endfunction : imdma_dur_of
endpackage : imdma_pkg
`default_nettype wire

/* File: sim/imdma_mem_model.sv */
// Memory partner model answering the DMA read cycles
`default_nettype none
module imdma_mem_model
  import imdma_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_bus_rd,
  input wire logic [ADDR_OUT_W-1:0] i_bus_addr,
  output logic [15:0] o_bus_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] last_r = 16'h0000;
  // Idle bus shows the inverse of the last word, so a late sample never matches
  always_comb o_bus_rdata = i_bus_rd ? (i_bus_addr[15:0] ^ 16'hA5C3) : ~last_r;
  always_ff @(posedge i_sys_clk) if (i_bus_rd) last_r <= o_bus_rdata;
endmodule : imdma_mem_model
`default_nettype wire

/* File: sim/tb_imdma_core.sv */
// Self-checking bench for the interrupt-driven micro DMA core
`default_nettype none
module tb_imdma_core
  import imdma_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_sys_clk = '0, i_resetn = '0, i_bus_release_ack = '1, i_interrupt_return = '0;
  logic i_io_wr = '0, i_io_rd = '0, i_ctl_wr = '0, i_ctl_rd = '0, i_ctl_priv = '0;
  logic [NSRC-1:0] i_irq_src = '0;
  logic [7:0] i_io_addr = '0, i_io_wdata = '0, o_io_rdata, o_int_vec, iv;
  logic [1:0] i_ctl_ch = '0, i_ctl_reg = '0;
  logic [31:0] i_ctl_wdata = '0, o_ctl_rdata, s, d, es, ed, st;
  logic [2:0] i_interrupt_return_mask = '0, o_saved_mask, o_cpu_priority_mask;
  logic o_int_req, o_busy, o_bus_rd, o_bus_wr, o_bus_word, z, wz;
  logic [ADDR_OUT_W-1:0] o_bus_addr, ra, wa;
  logic [15:0] o_bus_wdata, i_bus_rdata, wd;
  logic [31:0] lfsr = 32'h9670_279B;
  int n_mismatch = 0, cmp_count = 0, nb, ni, nr, nw;

  always #2.5 i_sys_clk = ~i_sys_clk;

  imdma_core i_imdma_core (.i_sys_clk, .i_resetn, .i_irq_src, .i_bus_release_ack, .i_io_wr,
    .i_io_rd, .i_io_addr, .i_io_wdata, .o_io_rdata, .i_ctl_wr, .i_ctl_rd, .i_ctl_priv,
    .i_ctl_ch, .i_ctl_reg, .i_ctl_wdata, .o_ctl_rdata, .i_interrupt_return, .i_interrupt_return_mask, .o_int_req,
    .o_int_vec, .o_saved_mask, .o_cpu_priority_mask, .o_busy, .o_bus_addr, .o_bus_rd,
    .o_bus_wr, .o_bus_word, .o_bus_wdata, .i_bus_rdata);
  imdma_mem_model i_imdma_mem_model (.i_sys_clk, .i_bus_rd(o_bus_rd),
    .i_bus_addr(o_bus_addr), .o_bus_rdata(i_bus_rdata));

  // ==========================================
  // Bench helpers
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Strobes left up by io or ctl drop here, so back-to-back calls never toggle them
  task automatic tick();
    i_io_wr = '0;
    i_io_rd = '0;
    i_ctl_wr = '0;
    i_ctl_rd = '0;
    @(posedge i_sys_clk);
    #1;
  endtask : tick

  task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] v);
    i_ctl_wr = '0;
    i_ctl_rd = '0;
    i_io_wr = wr;
    i_io_rd = ~wr;
    i_io_addr = a;
    i_io_wdata = v;
    @(posedge i_sys_clk);
    #1;
  endtask : io

  task automatic ctl(input logic wr, input logic pv, input logic [1:0] ch,
      input logic [1:0] r, input logic [31:0] v);
    i_io_wr = '0;
    i_io_rd = '0;
    i_ctl_wr = wr;
    i_ctl_rd = ~wr;
    i_ctl_priv = pv;
    i_ctl_ch = ch;
    i_ctl_reg = r;
    i_ctl_wdata = v;
    @(posedge i_sys_clk);
    #1;
  endtask : ctl

  task automatic interrupt_return(input logic [2:0] m);
    i_interrupt_return = '1;
    i_interrupt_return_mask = m;
    tick();
    i_interrupt_return = '0;
  endtask : interrupt_return

  task automatic fire(input logic [NSRC-1:0] v);
    i_irq_src = v;
    tick();
    i_irq_src = '0;
  endtask : fire

  // Observation window covers a whole run plus its end-of-run request
  task automatic watch(input int n);
    nb = 0;
    ni = 0;
    nr = 0;
    nw = 0;
    iv = '0;
    repeat (n) begin
      tick();
      nb += int'(o_busy === 1'b1);
      ni += int'(o_int_req === 1'b1);
      nr += int'(o_bus_rd === 1'b1);
      nw += int'(o_bus_wr === 1'b1);
      if (o_int_req === 1'b1) iv = o_int_vec;
      if (o_bus_rd === 1'b1) ra = o_bus_addr;
      if (o_bus_rd === 1'b1) wz = o_bus_word;
      if (o_bus_wr === 1'b1) wa = o_bus_addr;
      if (o_bus_wr === 1'b1) wd = o_bus_wdata;
    end
  endtask : watch

  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // ==========================================
  // Watchdog, generous against some 550 cycles of tests
  initial begin
    #100us;
    n_mismatch++;
    end_of_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    repeat (10) tick();
    i_resetn = '1;
    chk("mask", MASK_RESET, o_cpu_priority_mask);
    io(0, IO_SV_BASE, 8'h00);
    chk("sv0", SV_RESET, o_io_rdata);
    io(1, 8'h08, 8'h03);
    fire(20'h0_0100);
    watch(12);
    chk("blocked", 0, ni);
    io(0, 8'h08, 8'h00);
    chk("latch", 8'h0B, o_io_rdata);
    io(1, 8'h08, 8'h03);
    io(0, 8'h08, 8'h00);
    chk("clear", 8'h03, o_io_rdata);
    fire(20'h0_0100);
    interrupt_return(3'h0);
    watch(12);
    chk("vec", 8'h11, iv);
    chk("busy", 0, nb);
    chk("mask", 3'h4, o_cpu_priority_mask);
    chk("saved", 3'h0, o_saved_mask);
    io(0, 8'h08, 8'h00);
    chk("accept clr", 8'h03, o_io_rdata);
    io(1, 8'h09, 8'h04);
    fire(20'h0_0200);
    watch(12);
    chk("equal lvl", 0, ni);
    interrupt_return(3'h3);
    chk("reload", 3'h3, o_cpu_priority_mask);
    watch(12);
    chk("vec", 8'h12, iv);
    chk("mask", 3'h5, o_cpu_priority_mask);
    io(1, 8'h0A, 8'h02);
    io(1, 8'h0B, 8'h02);
    interrupt_return(3'h0);
    fire(20'h0_0C00);
    watch(12);
    chk("tie", 8'h13, iv);
    chk("one", 1, ni);
    interrupt_return(3'h0);
    watch(12);
    chk("tie2", 8'h14, iv);
    for (int l = 0; l < 8; l += 7) begin
      io(1, 8'h0E, l[7:0]);
      fire(20'h0_4000);
      watch(12);
      chk("off lvl", 0, ni);
    end
    interrupt_return(3'h7);
    fire(20'h0_0001);
    watch(12);
    chk("nmi", 8'h08, iv);
    interrupt_return(3'h0);
    // Ack goes low two edges ahead so the synchroniser has caught it
    i_bus_release_ack = '0;
    io(1, 8'h0C, 8'h01);
    fire(20'h0_1000);
    watch(12);
    chk("released", 0, ni);
    i_bus_release_ack = '1;
    watch(12);
    chk("returned", 8'h15, iv);
    interrupt_return(3'h0);
    for (int m = 0; m < 5; m++) begin
      s = rnd();
      d = rnd();
      z = m[0] ^ s[31];
      st = z ? 32'h0000_0002 : 32'h0000_0001;
      es = s;
      ed = d;
      case (m)
        0: ed = d + st;
        1: ed = d - st;
        2: es = s + st;
        3: es = s - st;
        default: ;
      endcase
      ctl(1, 1, 0, CR_SRC, s);
      ctl(1, 1, 0, CR_DST, d);
      ctl(1, 1, 0, CR_CNT, 32'h0000_0002);
      ctl(1, 1, 0, CR_MODE, {28'h0, m[2:0], z});
      io(1, IO_SV_BASE, 8'h11);
      fire(20'h0_0100);
      watch(24);
      chk("run len", 16, nb);
      chk("no int", 0, ni);
      chk("rd addr", s[23:0], ra);
      chk("wr addr", d[23:0], wa);
      chk("wdata", z ? s[15:0] ^ 16'hA5C3 : s[7:0] ^ 8'hC3, z ? wd : wd[7:0]);
      chk("rd size", z, wz);
      ctl(0, 0, 0, CR_SRC, 32'h0000_0000);
      chk("src", es, o_ctl_rdata);
      ctl(0, 0, 0, CR_DST, 32'h0000_0000);
      chk("dst", ed, o_ctl_rdata);
      fire(20'h0_0100);
      watch(24);
      chk("zero int", 8'h11, iv);
      interrupt_return(3'h0);
    end
    ctl(1, 1, 0, CR_SRC, 32'h0012_FFFE);
    ctl(1, 1, 0, CR_CNT, 32'h0000_0001);
    ctl(1, 1, 0, CR_MODE, {28'h0, MD_REFRESH});
    fire(20'h0_0100);
    watch(24);
    chk("refresh", 14, nb);
    chk("refr int", 0, ni + nw);
    chk("refr addr", 24'h12_FFFE, ra);
    chk("refr size", 1, wz);
    ctl(0, 0, 0, CR_SRC, 32'h0000_0000);
    chk("refr src", 32'h0012_0002, o_ctl_rdata);
    ctl(1, 1, 0, CR_CNT, 32'h0000_0001);
    ctl(1, 1, 0, CR_MODE, {28'h0, MD_COUNT});
    fire(20'h0_0100);
    watch(24);
    chk("count", 11, nb);
    chk("count bus", 0, nr + nw);
    chk("count int", 1, ni);
    interrupt_return(3'h0);
    ctl(1, 1, 1, CR_MODE, {28'h0, MD_COUNT});
    ctl(1, 1, 1, CR_CNT, 32'h0000_0007);
    ctl(1, 0, 1, CR_CNT, 32'h0000_0003);
    io(1, IO_SV_BASE + 8'h01, 8'h11);
    fire(20'h0_0100);
    watch(24);
    chk("wrap int", 0, ni);
    ctl(0, 0, 0, CR_CNT, 32'h0000_0000);
    chk("wrap", 32'h0000_FFFF, o_ctl_rdata);
    ctl(0, 0, 1, CR_CNT, 32'h0000_0000);
    chk("dup idle", 32'h0000_0007, o_ctl_rdata);
    end_of_test();
  end
endmodule : tb_imdma_core
`default_nettype wire
